/* pcg_pkg.sv */
// Purpose: shared constants and types for the port C output shaping block
// Assumes: 4-bit port, 8-bit registers on a 32-bit Avalon-MM word
// Notes: byte offsets, one aligned word per register
package pcg_pkg;
	localparam int PCG_PINS = 4;
	localparam int PCG_REG_W = 8;
	// register byte offsets
	localparam logic [4:0] PCG_OFF_OUTPUT_VALUE = 5'h00;
	localparam logic [4:0] PCG_OFF_DIRECTION = 5'h04;
	localparam logic [4:0] PCG_OFF_SLEW_CTRL = 5'h08;
	localparam logic [4:0] PCG_OFF_DRIVE_SEL = 5'h0c;
	localparam logic [4:0] PCG_OFF_GANG_CONTROL = 5'h10;
	// field positions in gang_control
	localparam int PCG_GANG_EN_BIT = 0;
	localparam int PCG_GANG_SEL_LSB = 1;
	localparam int PCG_GANG_SEL_MSB = 7;
	// gang select bits from this one up name pins outside port c
	localparam int PCG_GANG_EXT_LSB = 4;
	// reset values
	localparam logic [3:0] PCG_RST_PORT = 4'h0;
	localparam logic [7:0] PCG_RST_GANG = 8'h00;
	localparam logic [31:0] PCG_RST_RDATA = 32'h0000_0000;
	// pin synchroniser depth
	localparam int PCG_SYNC_STAGES = 3;

	typedef struct packed {
		logic [3:0] level;
		logic [3:0] oe;
		logic [3:0] slew;
		logic [3:0] drive;
	} pcg_pins_s;

	typedef struct packed {
		logic [3:0] ext_sel;
		logic level;
		logic drive;
		logic slew;
	} pcg_gang_ext_s;
endpackage : pcg_pkg

/* pcg_pin_sync.sv */
// Purpose: bring the port c pin levels into the bus clock domain
// Assumes: pins are asynchronous to i_clk
// Notes: level changes once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pcg_pin_sync
	import pcg_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// pins in, filtered level out
	input wire logic [3:0] i_pin,
	output logic [3:0] o_level
);
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [3:0] level_q;
	logic [3:0] level_d;

	always_comb begin
		level_d = level_q;
		for (int i = 0; i < PCG_PINS; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				level_d[i] = s3_q[i];
			end
		end
	end

	// s1 feeds only s2; metastability stays out of the compare
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= PCG_RST_PORT;
			s2_q <= PCG_RST_PORT;
			s3_q <= PCG_RST_PORT;
			level_q <= PCG_RST_PORT;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
		end
	end

	assign o_level = level_q;
endmodule : pcg_pin_sync
`default_nettype wire

/* pcg_port_top.sv */
// Purpose: port c output shaping and ganged drive, Avalon-MM slave
// Assumes: single 50 MHz clock, asynchronous active-high reset
// Notes: one wait state on every access
//
// Notes on behaviour
// - slew bit per pin limits slew when 1; ignored while pin is input
// - drive bit per pin picks high drive when 1; ignored for inputs
// - gang_control bits 7..1 are write-once pin selects for ganging
// - with gang on, selected pins copy pin zero level, drive and slew
// - a selected pin gangs only while gang enable is also 1
// - gang_control bit 0 is the write-once gang enable
// - gang enabled forces pin zero to output whatever direction says
// - direction 1 enables driver, reads give latch; 0 reads pin level, except pin zero with gang on
// - reset clears data latch; all pins become undriven inputs
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pcg_port_top
	import pcg_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// avalon-mm slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// port c pins
	input wire logic [3:0] i_pin,
	output pcg_pins_s o_pins,
	// ganged pins outside port c
	output pcg_gang_ext_s o_gang_ext
);
	////////////////////////////////////////////////////////////////////////
	// register state
	logic [3:0] out_val_q, out_val_d;
	logic [3:0] dir_q, dir_d;
	logic [3:0] slew_q, slew_d;
	logic [3:0] drive_q, drive_d;
	logic [7:0] gang_q, gang_d;
	logic gang_lock_q, gang_lock_d;
	// bus answer state, one bit so the two codes are gray by nature
	typedef enum logic {
		PCG_BUS_IDLE = 1'b0,
		PCG_BUS_ANSWER = 1'b1
	} pcg_bus_e;
	pcg_bus_e bus_q, bus_d;
	logic [31:0] rdata_q, rdata_d;
	logic [3:0] pin_level;
	logic access;
	logic wr_take;
	logic [3:0] eff_dir;
	logic [3:0] read_port;
	logic gang_en;
	logic [3:0] gang_sel;
	pcg_pins_s pins_d, pins_q;
	pcg_gang_ext_s gang_ext_d, gang_ext_q;
	// per-pin sources after the gang choice
	logic [3:0] gang_pick;
	logic [3:0] level_src;
	logic [3:0] slew_src;
	logic [3:0] drive_src;

	pcg_pin_sync u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin(i_pin),
		.o_level(pin_level)
	);

	////////////////////////////////////////////////////////////////////////
	// bus handshake: request held one cycle, answered on the second
	assign access = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = access && (bus_q == PCG_BUS_IDLE);
	// writes land only in the answer cycle, when the master is sure to hold
	assign wr_take = i_avs_write && (bus_q == PCG_BUS_ANSWER);
	assign o_avs_readdata = rdata_q;

	// one wait cycle per access; the answer state never lingers, so a
	// request still held after it is taken again as a new access
	always_comb begin
		bus_d = bus_q;
		case (bus_q)
			PCG_BUS_IDLE: begin
				if (access) begin
					bus_d = PCG_BUS_ANSWER;
				end
			end
			PCG_BUS_ANSWER: begin
				bus_d = PCG_BUS_IDLE;
			end
			default: begin
				bus_d = PCG_BUS_IDLE;
			end
		endcase
	end

	assign gang_en = gang_q[PCG_GANG_EN_BIT];
	// bit 0 of the pin mask is never ganged onto itself
	assign gang_sel = {gang_q[3:1], 1'b0};

	always_comb begin
		eff_dir = dir_q;
		eff_dir[0] = dir_q[0] | gang_en;
	end

	assign read_port = (eff_dir & out_val_q) | (~eff_dir & pin_level);

	always_comb begin
		out_val_d = out_val_q;
		dir_d = dir_q;
		slew_d = slew_q;
		drive_d = drive_q;
		gang_d = gang_q;
		gang_lock_d = gang_lock_q;
		rdata_d = rdata_q;
		if (wr_take && i_avs_byteenable[0]) begin
			case (i_avs_address)
				PCG_OFF_OUTPUT_VALUE: begin
					out_val_d = i_avs_writedata[3:0];
				end
				PCG_OFF_DIRECTION: begin
					dir_d = i_avs_writedata[3:0];
				end
				PCG_OFF_SLEW_CTRL: begin
					slew_d = i_avs_writedata[3:0];
				end
				PCG_OFF_DRIVE_SEL: begin
					drive_d = i_avs_writedata[3:0];
				end
				PCG_OFF_GANG_CONTROL: begin
					if (!gang_lock_q) begin
						gang_d = i_avs_writedata[7:0];
						gang_lock_d = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// capture while waiting so readdata stands in the answer cycle
		if (i_avs_read && (bus_q == PCG_BUS_IDLE)) begin
			case (i_avs_address)
				PCG_OFF_OUTPUT_VALUE: rdata_d = {28'h0000000, read_port};
				PCG_OFF_DIRECTION: rdata_d = {28'h0000000, dir_q};
				PCG_OFF_SLEW_CTRL: rdata_d = {28'h0000000, slew_q};
				PCG_OFF_DRIVE_SEL: rdata_d = {28'h0000000, drive_q};
				PCG_OFF_GANG_CONTROL: rdata_d = {24'h000000, gang_q};
				default: rdata_d = PCG_RST_RDATA;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin shaping
	// follow pin zero
	for (genvar g = 0; g < PCG_PINS; g++) begin : g_pin
		// pin zero is its own source, its select bit is forced off
		assign gang_pick[g] = gang_en & gang_sel[g];
		assign level_src[g] = gang_pick[g] ? out_val_q[0] : out_val_q[g];
		assign slew_src[g] = gang_pick[g] ? slew_q[0] : slew_q[g];
		assign drive_src[g] = gang_pick[g] ? drive_q[0] : drive_q[g];
	end

	always_comb begin
		pins_d.oe = eff_dir;
		pins_d.slew = slew_src & eff_dir;
		pins_d.drive = drive_src & eff_dir;
		// driven level only matters where oe is set
		pins_d.level = level_src & eff_dir;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			out_val_q <= PCG_RST_PORT;
			dir_q <= PCG_RST_PORT;
			slew_q <= PCG_RST_PORT;
			drive_q <= PCG_RST_PORT;
			gang_q <= PCG_RST_GANG;
			gang_lock_q <= 1'b0;
			bus_q <= PCG_BUS_IDLE;
			rdata_q <= PCG_RST_RDATA;
			pins_q <= '0;
			gang_ext_q <= '0;
		end else begin
			out_val_q <= out_val_d;
			dir_q <= dir_d;
			slew_q <= slew_d;
			drive_q <= drive_d;
			gang_q <= gang_d;
			gang_lock_q <= gang_lock_d;
			bus_q <= bus_d;
			rdata_q <= rdata_d;
			pins_q <= pins_d;
			gang_ext_q <= gang_ext_d;
		end
	end

	assign o_pins = pins_q;

	////////////////////////////////////////////////////////////////////////
	// ganged pins outside the port
	// ganged pins outside the port
	always_comb begin
		gang_ext_d.ext_sel = gang_en
			? gang_q[PCG_GANG_SEL_MSB:PCG_GANG_EXT_LSB] : 4'h0;
		gang_ext_d.level = out_val_q[0];
		gang_ext_d.drive = drive_q[0];
		gang_ext_d.slew = slew_q[0];
	end

	// registered so the outside pins move on the same edge as port c
	assign o_gang_ext = gang_ext_q;
endmodule : pcg_port_top
`default_nettype wire

/* pcg_port_sva.sv */
// Purpose: port c shaping checker
// Assumes: one clock domain
// Notes: pins lag registers by one clock
`timescale 1ns/1ns
`default_nettype none
module pcg_port_sva
	import pcg_pkg::*;
(
	// clock and bus
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	// pins
	input wire pcg_pins_s o_pins,
	input wire pcg_gang_ext_s o_gang_ext
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire logic g_on = o_gang_ext.ext_sel != 4'h0;
	a_slew_masked: assert property (
		(o_pins.slew & ~o_pins.oe) == 4'h0) else $error("slew undriven");
	a_drive_masked: assert property (
		(o_pins.drive & ~o_pins.oe) == 4'h0) else $error("drive undriven");
	a_level_masked: assert property (
		(o_pins.level & ~o_pins.oe) == 4'h0) else $error("level undriven");
	a_wait_once: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=>
		!o_avs_waitrequest) else $error("wait too long");
	a_idle_ready: assert property (
		!i_avs_read && !i_avs_write |-> !o_avs_waitrequest)
		else $error("wait while idle");
	a_gang_pin0: assert property (
		g_on |=> o_pins.oe[0]) else $error("pin zero not driven");
	a_gang_lock: assert property (
		g_on |=> $stable(o_gang_ext.ext_sel)) else $error("gang changed");
	a_gang_copy: assert property (
		g_on |-> {o_pins.level[0], o_pins.drive[0], o_pins.slew[0]} ==
		{o_gang_ext.level, o_gang_ext.drive, o_gang_ext.slew})
		else $error("gang copy");
	a_reset_clear: assert property (
		$fell(i_rst) |-> o_pins == '0 && o_gang_ext == '0)
		else $error("reset not clear");
	c_gang: cover property (g_on ##1 g_on);
	c_read: cover property (i_avs_read && !o_avs_waitrequest);
	c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule : pcg_port_sva
bind pcg_port_top pcg_port_sva u_sva (.i_clk(i_clk), .i_rst(i_rst),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest), .o_pins(o_pins),
	.o_gang_ext(o_gang_ext));
`default_nettype wire

/* pcg_load_model.sv */
// Purpose: external loads on port c pins
// Assumes: no pull devices on the board
// Notes: undriven pins follow the far source
`timescale 1ns/1ns
`default_nettype none
module pcg_load_model
	import pcg_pkg::*;
(
	// driven side and far source
	input wire pcg_pins_s i_pins,
	input wire logic [3:0] i_far,
	// resolved levels
	output logic [3:0] o_pin
);
	assign o_pin = (i_pins.oe & i_pins.level) | (~i_pins.oe & i_far);
endmodule : pcg_load_model
`default_nettype wire

/* port_c_output_shaping_gang_test.sv */
// Purpose: port c shaping bench
// Assumes: one wait state per access
// Notes: pins sampled two or six edges after writes
`timescale 1ns/1ns
`default_nettype none
module port_c_output_shaping_gang_test
	import pcg_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, q;
	logic wreq;
	logic [3:0] pin;
	logic [3:0] far = 4'h0;
	pcg_pins_s pins;
	pcg_gang_ext_s gx;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	always #10 i_clk = ~i_clk;
	pcg_port_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wreq), .i_pin(pin), .o_pins(pins),
		.o_gang_ext(gx));
	pcg_load_model u_load (.i_pins(pins), .i_far(far), .o_pin(pin));
	task automatic chk(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [4:0] a, input int d);
		@(posedge i_clk);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		do @(posedge i_clk); while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic print_verdict;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic t_reset;
		bus(1'b1, 5'h14, 'hff);
		for (int a = 0; a < 24; a += 4) begin
			bus(1'b0, 5'(a), 0);
			chk("reg", 0, q);
		end
		chk("pins", 0, 32'(pins));
		$display("t_reset done");
	endtask : t_reset
	task automatic t_io;
		far <= 4'hc;
		bus(1'b1, PCG_OFF_OUTPUT_VALUE, 5);
		bus(1'b1, PCG_OFF_DIRECTION, 3);
		bus(1'b1, PCG_OFF_SLEW_CTRL, 'hf);
		bus(1'b1, PCG_OFF_DRIVE_SEL, 'ha);
		repeat (6) @(posedge i_clk);
		chk("pins", 'h1332, 32'(pins));
		bus(1'b0, PCG_OFF_OUTPUT_VALUE, 0);
		chk("value", 'hd, q);
		$display("t_io done");
	endtask : t_io
	task automatic t_sel;
		bus(1'b1, PCG_OFF_GANG_CONTROL, 'hf6);
		bus(1'b1, PCG_OFF_GANG_CONTROL, 'h01);
		repeat (2) @(posedge i_clk);
		chk("pins", 'h1332, 32'(pins));
		chk("ext", 'h05, 32'(gx));
		bus(1'b0, PCG_OFF_GANG_CONTROL, 0);
		chk("gang", 'hf6, q);
		$display("t_sel done");
	endtask : t_sel
	task automatic t_gang;
		bus(1'b1, PCG_OFF_OUTPUT_VALUE, 1);
		bus(1'b1, PCG_OFF_DIRECTION, 6);
		bus(1'b1, PCG_OFF_SLEW_CTRL, 1);
		bus(1'b1, PCG_OFF_DRIVE_SEL, 1);
		bus(1'b1, PCG_OFF_GANG_CONTROL, 'h37);
		bus(1'b1, PCG_OFF_GANG_CONTROL, 0);
		repeat (2) @(posedge i_clk);
		chk("pins", 'h7777, 32'(pins));
		chk("ext", 'h1f, 32'(gx));
		bus(1'b0, PCG_OFF_GANG_CONTROL, 0);
		chk("gang", 'h37, q);
		bus(1'b0, PCG_OFF_DIRECTION, 0);
		chk("dir", 6, q);
		$display("t_gang done");
	endtask : t_gang
	// hang guard, about 110 cycles expected
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset;
		t_io;
		t_sel;
		i_rst <= 1'b1;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		t_gang;
		print_verdict;
	end
endmodule : port_c_output_shaping_gang_test
`default_nettype wire
